// [verilog/pattern_trigger_defs.vh]
// Register map, field layout and timing constants of the pattern trigger
`ifndef PATTERN_TRIGGER_DEFS_VH
`define PATTERN_TRIGGER_DEFS_VH

// Register byte offsets
`define REG_CARE_OFS      12'h000
`define REG_LEVEL_OFS     12'h004
`define REG_CTRL_OFS      12'h008
`define REG_LIMIT_LO_OFS  12'h00c
`define REG_LIMIT_HI_OFS  12'h010
`define REG_STATUS_OFS    12'h014
`define REG_COUNT_OFS     12'h018

// Control register fields
`define CTRL_FUNC_LSB     0
`define CTRL_FUNC_MSB     1
`define CTRL_QUAL_LSB     2
`define CTRL_QUAL_MSB     4
`define CTRL_ARM_BIT      8

// Logic functions
`define FUNC_AND          2'h0
`define FUNC_NAND         2'h1
`define FUNC_OR           2'h2
`define FUNC_NOR          2'h3

// Time qualifiers
`define QUAL_SHORTER      3'h0
`define QUAL_LONGER       3'h1
`define QUAL_TIMEOUT      3'h2
`define QUAL_INSIDE       3'h3
`define QUAL_OUTSIDE      3'h4

// Reset values
`define CARE_RST          17'h00000
`define LEVEL_RST         17'h00000
`define CTRL_RST          9'h000
`define LIMIT_RST         32'h00000001

// Least duration limit, in picoseconds, and clock period
`define MIN_LIMIT_PS      2000
`define CLK_PERIOD_PS     20000

`endif

// [verilog/pattern_trigger.v]
// Pattern trigger with time qualification, configured over APB
//
// Overview of operation
// - After holdoff, watch sixteen channels plus auxiliary
// - Per-input level high/low/ignore; ignored inputs excluded
// - AND: true when all cared inputs match
// - NAND: true when any cared input differs
// - OR: true when any cared input matches
// - NOR: true when all cared inputs differ
// - Start timing on rise, never trigger there
// - Non-timeout qualifiers decide at true-to-false edge
// - Shorter-than: trigger if duration below limit
// - Longer-than: trigger if duration beyond limit
// - Time-out: trigger the moment duration exceeds limit
// - Inside window: above minimum and below maximum
// - Outside window: below minimum or above maximum
// - No trigger when every input is ignored
// - Least limit 2 ns, rounded up to one 20 ns cycle
`timescale 1ns/1ps
`include "pattern_trigger_defs.vh"

module pattern_trigger #(
  parameter CH_W  = 16,
  parameter CNT_W = 32
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst_b,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Signals under test
  input  wire [CH_W-1:0]   channel_inputs,
  input  wire              aux_trig_in,
  input  wire              holdoff_done,
  // Trigger result
  output reg               trig_pulse,
  output reg               pattern_true
);

  localparam IN_W = CH_W + 1;
  // Least limit in cycles, rounded up, at least one
  localparam MIN_CYC = (`MIN_LIMIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam [CNT_W-1:0] MIN_LIMIT = MIN_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [IN_W-1:0]  care_r;
  reg [IN_W-1:0]  level_r;
  reg [1:0]       func_r;
  reg [2:0]       qual_r;
  reg             arm_r;
  reg [CNT_W-1:0] limit_lo_r;
  reg [CNT_W-1:0] limit_hi_r;
  reg [CNT_W-1:0] dur_r;
  reg [CNT_W-1:0] last_dur_r;
  reg             to_fired_r;
  reg             trig_seen_r;

  // Clamp a limit to the least programmable value
  function [CNT_W-1:0] clamp_limit;
    input [31:0] v;
    begin
      if (v[CNT_W-1:0] < MIN_LIMIT)
        clamp_limit = MIN_LIMIT;
      else
        clamp_limit = v[CNT_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pattern comparison

  wire [IN_W-1:0] in_vec   = {aux_trig_in, channel_inputs};
  wire [IN_W-1:0] match    = ~(in_vec ^ level_r) & care_r;
  wire [IN_W-1:0] differ   = (in_vec ^ level_r) & care_r;
  wire            any_care = |care_r;
  wire            all_match  = (match == care_r);
  wire            all_differ = (differ == care_r);
  reg             comb_true;

  always @*
  begin
    case (func_r)
      `FUNC_AND:  comb_true = all_match;
      `FUNC_NAND: comb_true = ~all_match;
      `FUNC_OR:   comb_true = |match;
      `FUNC_NOR:  comb_true = all_differ;
      default:    comb_true = 1'b0;
    endcase
  end

  // Monitoring only while armed, holdoff over and some input cared for
  wire active   = arm_r & holdoff_done & any_care;
  wire cur_true = active & comb_true;

  ////////////////////////////////////////////////////////////////////////////
  // Duration timing and qualification

  // Duration leaves out the cycle just ended when the pattern falls
  wire [CNT_W-1:0] dur_inc = (dur_r == {CNT_W{1'b1}}) ? dur_r : dur_r + 1'b1;
  wire falling = pattern_true & ~cur_true;
  reg  qual_ok;

  always @*
  begin
    case (qual_r)
      `QUAL_SHORTER: qual_ok = (dur_r < limit_lo_r);
      `QUAL_LONGER:  qual_ok = (dur_r > limit_lo_r);
      `QUAL_INSIDE:  qual_ok = (dur_r > limit_lo_r) && (dur_r < limit_hi_r);
      `QUAL_OUTSIDE: qual_ok = (dur_r < limit_lo_r) || (dur_r > limit_hi_r);
      default:       qual_ok = 1'b0;
    endcase
  end

  wire is_timeout = (qual_r == `QUAL_TIMEOUT);
  // Fires once when the running duration passes the limit
  wire to_hit = is_timeout & cur_true & pattern_true & ~to_fired_r
              & (dur_r >= limit_lo_r);

  // Trigger decided at a true-to-false edge
  wire fall_trig = falling & ~is_timeout & qual_ok;

  // Combined result registered, one cycle behind the inputs
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pattern_true <= 1'b0;
    else
      pattern_true <= cur_true;
  end

  // Running duration restarts at every rise and is dropped at a fall
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      dur_r <= {CNT_W{1'b0}};
    else if (cur_true && !pattern_true)
      dur_r <= {CNT_W{1'b0}};
    else if (falling)
      dur_r <= {CNT_W{1'b0}};
    else if (cur_true)
      dur_r <= dur_inc;
  end

  // Length of the last completed true period, for software
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      last_dur_r <= {CNT_W{1'b0}};
    else if (falling)
      last_dur_r <= dur_r;
  end

  // One time-out trigger per true period
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      to_fired_r <= 1'b0;
    else if (cur_true && !pattern_true)
      to_fired_r <= 1'b0;
    else if (to_hit)
      to_fired_r <= 1'b1;
  end

  // Trigger pulse lasts exactly one cycle
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      trig_pulse <= 1'b0;
    else
      trig_pulse <= to_hit | fall_trig;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, no wait state so every access answers in the second cycle

  // Every offset that answers without error
  function reg_mapped;
    input [11:0] a;
    begin
      case (a)
        `REG_CARE_OFS, `REG_LEVEL_OFS, `REG_CTRL_OFS, `REG_LIMIT_LO_OFS,
        `REG_LIMIT_HI_OFS, `REG_STATUS_OFS, `REG_COUNT_OFS:
          reg_mapped = 1'b1;
        default:
          reg_mapped = 1'b0;
      endcase
    end
  endfunction

  wire setup_ph = psel & ~penable;
  wire access   = psel & penable & pready;
  wire mapped   = reg_mapped(paddr);
  reg [31:0] rd_nxt;

  // Write strobes, taken at the access edge only
  wire wr_care  = access & pwrite & (paddr == `REG_CARE_OFS);
  wire wr_level = access & pwrite & (paddr == `REG_LEVEL_OFS);
  wire wr_ctrl  = access & pwrite & (paddr == `REG_CTRL_OFS);
  wire wr_lo    = access & pwrite & (paddr == `REG_LIMIT_LO_OFS);
  wire wr_hi    = access & pwrite & (paddr == `REG_LIMIT_HI_OFS);
  wire stat_clr = access & pwrite & (paddr == `REG_STATUS_OFS) & pwdata[0];

  // Sticky trigger flag: a trigger in the clear cycle still sets it
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      trig_seen_r <= 1'b0;
    else if (to_hit || fall_trig)
      trig_seen_r <= 1'b1;
    else if (stat_clr)
      trig_seen_r <= 1'b0;
  end

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `REG_CARE_OFS:     rd_nxt[IN_W-1:0] = care_r;
      `REG_LEVEL_OFS:    rd_nxt[IN_W-1:0] = level_r;
      `REG_CTRL_OFS:
      begin
        rd_nxt[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] = func_r;
        rd_nxt[`CTRL_QUAL_MSB:`CTRL_QUAL_LSB] = qual_r;
        rd_nxt[`CTRL_ARM_BIT]                 = arm_r;
      end
      `REG_LIMIT_LO_OFS: rd_nxt[CNT_W-1:0] = limit_lo_r;
      `REG_LIMIT_HI_OFS: rd_nxt[CNT_W-1:0] = limit_hi_r;
      `REG_STATUS_OFS:   rd_nxt[2:0] = {any_care, pattern_true, trig_seen_r};
      `REG_COUNT_OFS:    rd_nxt[CNT_W-1:0] = last_dur_r;
      default:           rd_nxt = 32'h00000000;
    endcase
  end

  // Pattern definition
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      care_r  <= `CARE_RST;
      level_r <= `LEVEL_RST;
    end
    else
    begin
      if (wr_care)
        care_r <= pwdata[IN_W-1:0];
      if (wr_level)
        level_r <= pwdata[IN_W-1:0];
    end
  end

  // Function, qualifier and arm; disarming mid-pattern acts as a fall
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      func_r <= `FUNC_AND;
      qual_r <= `QUAL_SHORTER;
      arm_r  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      func_r <= pwdata[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
      qual_r <= pwdata[`CTRL_QUAL_MSB:`CTRL_QUAL_LSB];
      arm_r  <= pwdata[`CTRL_ARM_BIT];
    end
  end

  // Limits never fall below the least programmable value
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      limit_lo_r <= `LIMIT_RST;
      limit_hi_r <= `LIMIT_RST;
    end
    else
    begin
      if (wr_lo)
        limit_lo_r <= clamp_limit(pwdata);
      if (wr_hi)
        limit_hi_r <= clamp_limit(pwdata);
    end
  end

  // Bus answer: no wait state, ready in the first access cycle, error on an unmapped offset
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph)
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
    end
  end

endmodule

// [test/pattern_trigger_sva.sv]
// Port-level properties of the pattern trigger
`timescale 1ns/1ps
module pattern_trigger_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Trigger side
  input wire logic holdoff_done,
  input wire logic trig_pulse,
  input wire logic pattern_true
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  pulse_one_a: assert property (trig_pulse |=> !trig_pulse)
    else $error("trigger wider than one cycle");
  rise_quiet_a: assert property ($rose(pattern_true) |-> !trig_pulse)
    else $error("trigger at pattern rise");
  pulse_cause_a: assert property (trig_pulse |-> $past(pattern_true))
    else $error("trigger without true pattern");
  gate_true_a: assert property (!holdoff_done |=> !pattern_true)
    else $error("pattern true during holdoff");
  gate_trig_a: assert property (!holdoff_done [*2] |=> !trig_pulse)
    else $error("trigger during holdoff");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Goals the scenarios must reach
  cover property (trig_pulse);
  cover property ($fell(pattern_true));
  cover property (pslverr);
endmodule
bind pattern_trigger pattern_trigger_sva u_sva (.*);

// [test/sig_src.sv]
// Model of the signals under test on the channel and auxiliary inputs
`timescale 1ns/1ps
module sig_src (
  // Clock and command
  input  wire logic  sys_clk,
  input  wire logic  drive_match,
  // Signals under test
  output logic [15:0] channel_inputs,
  output logic        aux_trig_in
);
  ////////////////////////////////////////
  // Ignored bits swap too, so masking is exercised
  initial {aux_trig_in, channel_inputs} = 17'h1aaaa;
  always @(posedge sys_clk)
    {aux_trig_in, channel_inputs} <= drive_match ? 17'h05555 : 17'h1aaaa;
endmodule

// [test/pattern_trigger_tb.sv]
// Self-checking bench for the pattern trigger
`timescale 1ns/1ps
`include "pattern_trigger_defs.vh"
module pattern_trigger_tb;
  logic        sys_clk = 0;
  logic        rst_b = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        holdoff_done = 1;
  logic        drive_match = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] channel_inputs;
  logic        pready, pslverr, aux_trig_in, trig_pulse, pattern_true, er;
  int          err_count = 0;
  int          checks_done = 0;
  int          pulses = 0;
  int          f, q;
  int          lens[4] = '{3, 4, 5, 8};

  initial forever #10 sys_clk = ~sys_clk;
  pattern_trigger u_pattern_trigger (.*);
  sig_src u_sig_src (.*);
  always @(posedge sys_clk) if (trig_pulse === 1'b1) pulses <= pulses + 1;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      err_count++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Limits 3 and 6; timeout fires once the length passes the limit
  function automatic int exp_trig(int ql, int d);
    case (ql)
      0: return d < 3;
      1, 2: return d > 3;
      3: return d > 3 && d < 6;
      default: return d < 3 || d > 6;
    endcase
  endfunction

  // Disarmed while idling so a function change cannot start a period
  task automatic run(input logic [1:0] fn, input int ql, input int len, input int ex,
                     input logic pt);
    int p0;
    xfer(1, `REG_CTRL_OFS, 0);
    drive_match <= fn[0];
    repeat (4) @(posedge sys_clk);
    xfer(1, `REG_CTRL_OFS, 32'h100 | (ql << 2) | fn);
    repeat (3) @(posedge sys_clk);
    p0 = pulses;
    drive_match <= !fn[0];
    repeat (len) @(posedge sys_clk);
    chk(pattern_true, pt);
    drive_match <= fn[0];
    repeat (5) @(posedge sys_clk);
    chk(pulses - p0, ex);
  endtask

  task automatic finish_test();
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    fork
      begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
      end
    join_none
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    xfer(0, `REG_CARE_OFS, 0);
    chk(rd, `CARE_RST);
    xfer(0, `REG_LIMIT_LO_OFS, 0);
    chk(rd, `LIMIT_RST);
    xfer(0, 12'h01c, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    xfer(1, `REG_CARE_OFS, 32'h10001);
    xfer(1, `REG_LEVEL_OFS, 32'h1);
    xfer(1, `REG_LIMIT_LO_OFS, 3);
    xfer(1, `REG_LIMIT_HI_OFS, 6);
    for (f = 0; f < 4; f++)
      for (q = 0; q < 5; q++)
        foreach (lens[i])
          run(f, q, lens[i], exp_trig(q, lens[i] - 1), 1);
    xfer(0, `REG_COUNT_OFS, 0);
    chk(rd, 7);
    xfer(0, `REG_STATUS_OFS, 0);
    chk(rd, 32'h5);
    xfer(1, `REG_STATUS_OFS, 1);
    xfer(0, `REG_STATUS_OFS, 0);
    chk(rd, 32'h4);
    holdoff_done <= 0;
    run(0, 1, 8, 0, 0);
    holdoff_done <= 1;
    xfer(1, `REG_CARE_OFS, 0);
    run(0, 2, 8, 0, 0);
    finish_test();
  end
endmodule
